// [logic/watchdog_regs.svh]
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// byte addresses of the registers
`define WDG_ADDR_COUNT 8'hD8
`define WDG_ADDR_STATUS 8'hDC

// watchdog_count_control layout and reset value
`define WDG_COUNT_RESET 8'hFE
`define WDG_BIT_ACT 0
`define WDG_BIT_SR 1
`define WDG_T_TOP 7
`define WDG_T_BITS 6
`define WDG_CNT_SR 6

// status register layout
`define WDG_ST_ACTIVE 0
`define WDG_ST_STOP 1
`define WDG_ST_CAUSE 2

// timing counts in internal clock cycles, except the stage count, which counts divide-by-twelve steps
`define WDG_PRESC_DIV 4'hC
`define WDG_PRESC_STAGE 9'h100
`define WDG_RST_HOLD 12'h800

// bus answers
`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

`endif

// [logic/watchdog_pkg.sv]
`default_nettype none
package watchdog_pkg;

    // sleep state of the core as seen by the watchdog
    typedef enum logic [1:0] {
        SLP_RUN = 2'b00,
        SLP_WAIT = 2'b01,
        SLP_STOP = 2'b10
    } sleep_state_t;

endpackage
`default_nettype wire

// [logic/wdg_link_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface wdg_link_if;
    logic tick;
    logic freeze;
    logic trigger;
    logic core_rst;
    logic restart;

    modport presc (input freeze, input restart, output tick);
    modport stretch (input trigger, output core_rst);
    modport hub (output freeze, output trigger, output restart, input tick,
        input core_rst);
endinterface
`default_nettype wire

// [logic/wdg_prescaler.sv]
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_regs.svh"
module wdg_prescaler (
    input wire logic clk_i,
    input wire logic resetn_i,
    wdg_link_if.presc link
);
    logic [3:0] div_r;
    logic [3:0] div_nxt;
    logic [8:0] stg_r;
    logic [8:0] stg_nxt;
    logic tick_r;
    logic tick_nxt;

    ////////////////////////////////////////////////////////////////////////
    // divide by twelve, then by the period stage; held while frozen
    // restart on reload so a period never starts part way through a stage
    always_comb begin
        div_nxt = div_r;
        stg_nxt = stg_r;
        tick_nxt = 1'b0;
        if (link.restart) begin
            div_nxt = 4'h0;
            stg_nxt = 9'h000;
        end else if (!link.freeze) begin
            if (div_r == `WDG_PRESC_DIV - 4'h1) begin
                div_nxt = 4'h0;
                if (stg_r == `WDG_PRESC_STAGE - 9'h001) begin
                    stg_nxt = 9'h000;
                    tick_nxt = 1'b1;
                end else begin
                    stg_nxt = stg_r + 9'h001;
                end
            end else begin
                div_nxt = div_r + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_r <= 4'h0;
            stg_r <= 9'h000;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            stg_r <= stg_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign link.tick = tick_r;
endmodule
`default_nettype wire

// [logic/wdg_reset_stretch.sv]
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_regs.svh"
module wdg_reset_stretch (
    input wire logic clk_i,
    input wire logic resetn_i,
    wdg_link_if.stretch link
);
    logic [11:0] hold_r;
    logic [11:0] hold_nxt;
    logic rst_r;
    logic rst_nxt;

    ////////////////////////////////////////////////////////////////////////
    // internal reset held for the stabilisation delay after any source
    always_comb begin
        if (link.trigger) begin
            hold_nxt = `WDG_RST_HOLD;
        end else if (hold_r != 12'h000) begin
            hold_nxt = hold_r - 12'h001;
        end else begin
            hold_nxt = hold_r;
        end
        rst_nxt = (hold_nxt != 12'h000);
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hold_r <= `WDG_RST_HOLD;
            rst_r <= 1'b1;
        end else begin
            hold_r <= hold_nxt;
            rst_r <= rst_nxt;
        end
    end

    assign link.core_rst = rst_r;
endmodule
`default_nettype wire

// [logic/watchdog_top.sv]
// Contract
// - active counter expiry resets whole device
// - software option: disabled until activation bit written
// - once active, stays active until reset
// - hardware option: activation bit always one
// - hardware, no external stop: stop becomes wait
// - external stop, pin low: stop becomes wait
// - external stop, pin high: freeze, enter stop
// - wake from stop resumes counting held value
// - any reset loads register with FEh
// - soft reset bit falling resets device
// - period bits reversed onto counter bits
// - reset fires when counter bit six falls
// - 64 periods, 3072 to 196608 cycles
// - inactive counter works as 7-bit timer
// - counter clocked by internal clock over 3072 (twelve, then 256)
// - watchdog reset restarts like external reset
// - internal reset held 2048 cycles after release
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_regs.svh"
module watchdog_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    // hardware options, taken while the internal reset is held
    input wire logic opt_hw_activate_i,
    input wire logic opt_ext_stop_i,
    // core sleep handshake
    input wire logic sleep_req_i,
    input wire logic wake_irq_i,
    input wire logic nmi_pin_i,
    output logic core_reset_o,
    output logic stop_mode_o,
    output logic wait_mode_o,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    wdg_link_if link ();

    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic act_r;
    logic act_nxt;
    logic opt_hw_r;
    logic opt_hw_nxt;
    logic opt_ext_r;
    logic opt_ext_nxt;
    logic cause_r;
    logic cause_nxt;
    logic trig;
    watchdog_pkg::sleep_state_t slp_r;
    watchdog_pkg::sleep_state_t slp_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic wr_go;
    logic rd_go;
    logic wr_count;
    logic wr_status;
    logic act_eff;
    logic [7:0] count_view;
    logic [6:0] wr_cnt;
    logic [6:0] init_cnt;
    logic [7:0] init_reg;

    ////////////////////////////////////////////////////////////////////////
    // helpers: prescaler and reset stretcher
    wdg_prescaler u_presc (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .link(link)
    );

    wdg_reset_stretch u_stretch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .link(link)
    );

    ////////////////////////////////////////////////////////////////////////
    // reversed mapping of period bits onto the physical counter
    assign init_reg = `WDG_COUNT_RESET;
    genvar gi;
    generate
        for (gi = 0; gi < `WDG_T_BITS; gi = gi + 1) begin : g_map
            assign count_view[`WDG_T_TOP - gi] = cnt_r[gi];
            assign wr_cnt[gi] = s_axi_wdata[`WDG_T_TOP - gi];
            assign init_cnt[gi] = init_reg[`WDG_T_TOP - gi];
        end
    endgenerate
    assign count_view[`WDG_BIT_SR] = cnt_r[`WDG_CNT_SR];
    assign count_view[`WDG_BIT_ACT] = act_eff;
    assign wr_cnt[`WDG_CNT_SR] = s_axi_wdata[`WDG_BIT_SR];
    assign init_cnt[`WDG_CNT_SR] = init_reg[`WDG_BIT_SR];
    assign act_eff = act_r | opt_hw_r;

    ////////////////////////////////////////////////////////////////////////
    // bus write and read decode
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
    assign rd_go = s_axi_arvalid & ~rvalid_r;
    assign wr_count = wr_go & s_axi_wstrb[0]
        & (s_axi_awaddr == `WDG_ADDR_COUNT);
    assign wr_status = wr_go & s_axi_wstrb[0]
        & (s_axi_awaddr == `WDG_ADDR_STATUS);
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;

    ////////////////////////////////////////////////////////////////////////
    // counter, activation and reset trigger
    always_comb begin
        cnt_nxt = cnt_r;
        act_nxt = act_r;
        trig = 1'b0;
        if (link.core_rst) begin
            cnt_nxt = init_cnt;
            act_nxt = 1'b0;
        end else if (wr_count) begin
            cnt_nxt = wr_cnt;
            act_nxt = act_r | s_axi_wdata[`WDG_BIT_ACT];
            if (cnt_r[`WDG_CNT_SR] && !wr_cnt[`WDG_CNT_SR]) begin
                trig = 1'b1;
            end
        end else if (link.tick) begin
            cnt_nxt = cnt_r - 7'h01;
            if (act_eff && cnt_r[`WDG_CNT_SR]
                && !cnt_nxt[`WDG_CNT_SR]) begin
                trig = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // options follow the pins only while the internal reset is held
    always_comb begin
        opt_hw_nxt = opt_hw_r;
        opt_ext_nxt = opt_ext_r;
        if (link.core_rst) begin
            opt_hw_nxt = opt_hw_activate_i;
            opt_ext_nxt = opt_ext_stop_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watchdog reset cause, set wins over write-one-to-clear
    always_comb begin
        cause_nxt = cause_r;
        if (wr_status && s_axi_wdata[`WDG_ST_CAUSE]) begin
            cause_nxt = 1'b0;
        end
        if (trig) begin
            cause_nxt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep handling: real stop or idle wait
    always_comb begin
        slp_nxt = slp_r;
        case (slp_r)
            watchdog_pkg::SLP_RUN: begin
                if (sleep_req_i) begin
                    if (!act_eff || (opt_ext_r && nmi_pin_i)) begin
                        slp_nxt = watchdog_pkg::SLP_STOP;
                    end else begin
                        slp_nxt = watchdog_pkg::SLP_WAIT;
                    end
                end
            end
            watchdog_pkg::SLP_WAIT: begin
                if (wake_irq_i) begin
                    slp_nxt = watchdog_pkg::SLP_RUN;
                end
            end
            watchdog_pkg::SLP_STOP: begin
                if (wake_irq_i) begin
                    slp_nxt = watchdog_pkg::SLP_RUN;
                end
            end
            default: begin
                slp_nxt = watchdog_pkg::SLP_RUN;
            end
        endcase
        if (link.core_rst) begin
            slp_nxt = watchdog_pkg::SLP_RUN;
        end
    end

    assign link.trigger = trig;
    assign link.restart = link.core_rst | wr_count;
    assign link.freeze = link.core_rst
        | (slp_r == watchdog_pkg::SLP_STOP);

    ////////////////////////////////////////////////////////////////////////
    // bus answers: write response and read data
    always_comb begin
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            if (s_axi_awaddr == `WDG_ADDR_COUNT
                || s_axi_awaddr == `WDG_ADDR_STATUS) begin
                bresp_nxt = `WDG_RESP_OKAY;
            end else begin
                bresp_nxt = `WDG_RESP_SLVERR;
            end
        end
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `WDG_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (s_axi_araddr)
                `WDG_ADDR_COUNT: begin
                    rdata_nxt[7:0] = count_view;
                end
                `WDG_ADDR_STATUS: begin
                    rdata_nxt[`WDG_ST_ACTIVE] = act_eff;
                    rdata_nxt[`WDG_ST_STOP] =
                        (slp_r == watchdog_pkg::SLP_STOP);
                    rdata_nxt[`WDG_ST_CAUSE] = cause_r;
                end
                default: begin
                    rresp_nxt = `WDG_RESP_SLVERR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 7'h7F;
            act_r <= 1'b0;
            opt_hw_r <= 1'b0;
            opt_ext_r <= 1'b0;
            cause_r <= 1'b0;
            slp_r <= watchdog_pkg::SLP_RUN;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h0000_0000;
        end else begin
            cnt_r <= cnt_nxt;
            act_r <= act_nxt;
            opt_hw_r <= opt_hw_nxt;
            opt_ext_r <= opt_ext_nxt;
            cause_r <= cause_nxt;
            slp_r <= slp_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign core_reset_o = link.core_rst;
    assign stop_mode_o = (slp_r == watchdog_pkg::SLP_STOP);
    assign wait_mode_o = (slp_r == watchdog_pkg::SLP_WAIT);
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
endmodule
`default_nettype wire

// [testbench/watchdog_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module watchdog_top_asserts (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic opt_hw_activate_i,
    input wire logic opt_ext_stop_i,
    input wire logic sleep_req_i,
    input wire logic wake_irq_i,
    input wire logic nmi_pin_i,
    input wire logic core_reset_o,
    input wire logic stop_mode_o,
    input wire logic wait_mode_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid
);
default clocking cb @(posedge clk_i); endclocking
default disable iff (!resetn_i);
logic [11:0] hold_cnt_r;
logic [11:0] hold_cnt_nxt;
wire logic sleep_taken = sleep_req_i && !core_reset_o && !stop_mode_o
    && !wait_mode_o;
////////////////////////////////////////////////////////////////////////////
// length of the current internal reset
always_comb hold_cnt_nxt = core_reset_o ? hold_cnt_r + 12'h001 : 12'h000;
always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) hold_cnt_r <= 12'h000;
    else hold_cnt_r <= hold_cnt_nxt;
end
////////////////////////////////////////////////////////////////////////////
hold_min_a: assert property (
    core_reset_o && hold_cnt_r < 12'h7FF |=> core_reset_o)
    else $error("internal reset released early");
hold_max_a: assert property (
    core_reset_o |-> hold_cnt_r < 12'h802)
    else $error("internal reset held too long");
hw_wait_a: assert property (
    sleep_taken && opt_hw_activate_i && !opt_ext_stop_i
    |=> wait_mode_o && !stop_mode_o)
    else $error("stop not turned into wait");
ext_low_a: assert property (
    sleep_taken && opt_hw_activate_i && opt_ext_stop_i && !nmi_pin_i
    |=> wait_mode_o && !stop_mode_o)
    else $error("low pin did not give wait");
ext_high_a: assert property (
    sleep_taken && opt_ext_stop_i && nmi_pin_i |=> stop_mode_o && !wait_mode_o)
    else $error("high pin did not give stop");
stop_hold_a: assert property (
    stop_mode_o && !wake_irq_i && !core_reset_o |=> stop_mode_o)
    else $error("stop left without wake");
wake_clear_a: assert property (
    (stop_mode_o || wait_mode_o) && wake_irq_i |=> !stop_mode_o && !wait_mode_o)
    else $error("wake did not resume run");
wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid)
    else $error("write answer late");
rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind watchdog_top watchdog_top_asserts u_chk (.clk_i, .resetn_i,
    .opt_hw_activate_i, .opt_ext_stop_i, .sleep_req_i, .wake_irq_i,
    .nmi_pin_i, .core_reset_o, .stop_mode_o, .wait_mode_o, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_bvalid, .s_axi_rvalid);
`default_nettype wire

// [testbench/core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input wire logic clk_i,
    output logic sleep_req_o,
    output logic wake_irq_o,
    output logic nmi_pin_o
);
// idle core, pin pulled high
initial begin
    sleep_req_o = 1'b0;
    wake_irq_o = 1'b0;
    nmi_pin_o = 1'b1;
end
// one-cycle sleep instruction at a chosen pin level
task automatic sleep(input logic nmi);
    @(posedge clk_i);
    nmi_pin_o <= nmi;
    sleep_req_o <= 1'b1;
    @(posedge clk_i);
    sleep_req_o <= 1'b0;
endtask
// one-cycle interrupt ending wait or stop
task automatic wake();
    @(posedge clk_i);
    wake_irq_o <= 1'b1;
    @(posedge clk_i);
    wake_irq_o <= 1'b0;
endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "watchdog_regs.svh"
module tb;
logic clk_i, resetn_i, opt_hw_activate_i, opt_ext_stop_i;
logic sleep_req_i, wake_irq_i, nmi_pin_i;
logic core_reset_o, stop_mode_o, wait_mode_o;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
logic s_axi_rvalid, s_axi_rready;
int n_mismatch = 0;
int num_checks = 0;
int c;
logic [33:0] rq[$];
logic [1:0] bq[$];
watchdog_top dut (.clk_i, .resetn_i, .opt_hw_activate_i, .opt_ext_stop_i,
    .sleep_req_i, .wake_irq_i, .nmi_pin_i, .core_reset_o, .stop_mode_o,
    .wait_mode_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
core_model core (.clk_i, .sleep_req_o(sleep_req_i), .wake_irq_o(wake_irq_i),
    .nmi_pin_o(nmi_pin_i));
////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    num_checks++;
    if (got !== exp) begin
        n_mismatch++;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
endtask
task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
        $display("Regression OK");
    end else begin
        $display("Regression broken");
    end
    $finish;
endtask
// one write, answer noted for the monitor
task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk_i); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk_i); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
endtask
// one read, data and answer noted for the monitor
task automatic rd(input logic [7:0] a, input logic [7:0] d,
    input logic [1:0] r);
    rq.push_back({24'h000000, d, r});
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
endtask
// cycles until the internal reset reaches a level
task automatic tmo(input logic v);
    c = 0;
    while (core_reset_o !== v && c < 8000) begin
        @(posedge clk_i);
        #1;
        c++;
    end
endtask
task automatic rst(input logic h, input logic e);
    @(posedge clk_i);
    opt_hw_activate_i <= h;
    opt_ext_stop_i <= e;
    resetn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    tmo(1'b0);
    chk(c, 2048);
endtask
////////////////////////////////////////////////////////////////////////////
// monitor: compare answers against the oldest note
always @(posedge clk_i) begin
    if (s_axi_bvalid && s_axi_bready) chk(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rdata, s_axi_rresp},
        rq.pop_front());
end
initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
end
// hang guard
initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
end
initial begin
    resetn_i = 1'b0;
    {opt_hw_activate_i, opt_ext_stop_i, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_wstrb} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    void'($urandom(32'h917B));
    rst(1'b0, 1'b0);
    rd(`WDG_ADDR_COUNT, `WDG_COUNT_RESET, `WDG_RESP_OKAY);
    wr(`WDG_ADDR_COUNT, $urandom(), 4'h0, `WDG_RESP_OKAY);
    rd(`WDG_ADDR_COUNT, `WDG_COUNT_RESET, `WDG_RESP_OKAY);
    rd(8'hE0 + 8'($urandom_range(3) * 4), 8'h00, `WDG_RESP_SLVERR);
    core.sleep(1'b0);
    #1 chk({stop_mode_o, wait_mode_o}, 2'b10);
    core.wake();
    #1 chk({stop_mode_o, wait_mode_o}, 2'b00);
    wr(`WDG_ADDR_COUNT, 32'h02, 4'h1, `WDG_RESP_OKAY);
    repeat (3500) @(posedge clk_i);
    chk(core_reset_o, 1'b0);
    rd(`WDG_ADDR_COUNT, 8'hFC, `WDG_RESP_OKAY);
    wr(`WDG_ADDR_COUNT, 32'hFE, 4'h1, `WDG_RESP_OKAY);
    wr(`WDG_ADDR_COUNT, 32'hFC, 4'h1, `WDG_RESP_OKAY);
    tmo(1'b1);
    chk(c <= 3, 1'b1);
    tmo(1'b0);
    // reset already stood one edge when the write task returned
    chk(c, 2047);
    rd(`WDG_ADDR_COUNT, `WDG_COUNT_RESET, `WDG_RESP_OKAY);
    rd(`WDG_ADDR_STATUS, 8'h04, `WDG_RESP_OKAY);
    wr(`WDG_ADDR_STATUS, 32'h04, 4'h1, `WDG_RESP_OKAY);
    rd(`WDG_ADDR_STATUS, 8'h00, `WDG_RESP_OKAY);
    $display("test timer and soft reset finished");
    wr(`WDG_ADDR_COUNT, 32'h03, 4'h1, `WDG_RESP_OKAY);
    repeat (3) begin
        repeat (2000) @(posedge clk_i);
        wr(`WDG_ADDR_COUNT, 32'h03, 4'h1, `WDG_RESP_OKAY);
    end
    chk(core_reset_o, 1'b0);
    wr(`WDG_ADDR_COUNT, 32'h02, 4'h1, `WDG_RESP_OKAY);
    rd(`WDG_ADDR_COUNT, 8'h03, `WDG_RESP_OKAY);
    tmo(1'b1);
    chk(c inside {[3030:3080]}, 1'b1);
    tmo(1'b0);
    $display("test software activation finished");
    rst(1'b1, 1'b0);
    rd(`WDG_ADDR_COUNT, 8'hFF, `WDG_RESP_OKAY);
    wr(`WDG_ADDR_COUNT, 32'hFE, 4'h1, `WDG_RESP_OKAY);
    rd(`WDG_ADDR_COUNT, 8'hFF, `WDG_RESP_OKAY);
    core.sleep(1'b1);
    #1 chk({stop_mode_o, wait_mode_o}, 2'b01);
    core.wake();
    $display("test hardware activation finished");
    rst(1'b1, 1'b1);
    wr(`WDG_ADDR_COUNT, 32'h03, 4'h1, `WDG_RESP_OKAY);
    core.sleep(1'b0);
    #1 chk({stop_mode_o, wait_mode_o}, 2'b01);
    core.wake();
    core.sleep(1'b1);
    #1 chk({stop_mode_o, wait_mode_o}, 2'b10);
    repeat (4000) @(posedge clk_i);
    chk({core_reset_o, stop_mode_o}, 2'b01);
    core.wake();
    tmo(1'b1);
    chk(c > 0 && c < 3100, 1'b1);
    tmo(1'b0);
    $display("test external stop finished");
    end_sim();
end
endmodule
`default_nettype wire
